// File: hw/sleep_wake_map.vh
/*
  constants for the sleep/wake and tamper alarm supervisor: apb register map,
  field positions, reset values, flow-control characters and timing counts.
  assumes a 25 mhz pclk; included by bare name from the supervisor design file.
*/
`ifndef SLEEP_WAKE_MAP_VH
`define SLEEP_WAKE_MAP_VH

// ==================================================
// register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_IRQ_STAT 12'h008
`define OFS_IRQ_EN 12'h00C
`define OFS_IRQ_CLR 12'h010
`define OFS_TAMPER_MSG 12'h014
`define OFS_TX_CHAR 12'h018

// ==================================================
// ctrl fields
`define CTRL_XONOFF 0
`define CTRL_REPORT 1
`define CTRL_GPIO_LO 2
`define CTRL_GPIO_HI 4
`define CTRL_THR_LO 8
`define CTRL_THR_HI 15
`define CTRL_RESET 32'h0000_0100

// ==================================================
// interrupt bits
`define IRQ_SLEEP 0
`define IRQ_WAKE 1
`define IRQ_JOIN 2
`define IRQ_ALARM 3
`define IRQ_MSG 4
`define IRQ_W 5

// ==================================================
// characters
`define CHR_PROMPT 8'h3E
`define CHR_SLEEP 8'h5A
`define CHR_XOFF 8'h13
`define CHR_XON 8'h11

// ==================================================
// timing
`define CLK_HZ 25000000
`define XON_PERIOD_S 1
`define XON_CYC (`CLK_HZ * `XON_PERIOD_S)
`define MIN_PERIOD_S 60
`define HOUR_MINUTES 60
`define RESET_CYC_NS 1000
`define RESET_CYC (`RESET_CYC_NS / 40)

`endif

// File: hw/tick_divider.v
/*
  divider that turns pclk into a one-cycle enable pulse every period cycles.
  assumes a free-running pclk and asynchronous active-low reset.
*/
`timescale 1ns/1ps
module tick_divider #(
  parameter PERIOD = 25000000
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire clear,
  // tick out
  output reg tick
);

  reg [31:0] count;

  // ==================================================
  // counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (clear) begin
      count <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (count == PERIOD - 1) begin
      count <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

endmodule

// File: hw/sleep_wake_tamper_alarm.v
/*
  supervisor of sleep, wake-up and rf tamper alarm for a serial mesh module.
  the uart itself sits outside: received characters arrive as rx_valid/rx_data
  and outgoing characters leave as tx_valid/tx_data with tx_ready from the uart.
  mesh join, radio link and interference flags come from the radio core on pclk.
  config_select is a pin and is synchronised here.
*/
// Overview of operation
// R1: host pulls config low, awaits prompt
// R2: sleep command in config mode sleeps
// R3: config high in sleep wakes, full reset
// R4: pull-ups off while asleep
// R5: host drives config high push-pull
// R6: cts high in reset, low on join
// R7: one xoff after reset, xon after join
// R8: xoff 13h, xon 11h, xon every second
// R9: connection led flashes after wake
// R10: reset message, cause sleep wake
// R11: status report only if enabled
// R12: alarm gpio low during tamper
// R13: alarm gpio high when tamper ends
// R14: alarm gpio index 0 to 7
// R15: host sets alarm gpio as output
// R16: alarm after threshold continuous minutes
// R17: queue alarm message, send on link
// R18: message high minutes, low hours since
// R19: minute count clears when interference stops; kept here while the alarm is on or its message is queued
`timescale 1ns/1ps
`include "sleep_wake_map.vh"
module sleep_wake_tamper_alarm #(
  parameter XON_CYCLES = `XON_CYC,
  parameter MIN_TICKS = `MIN_PERIOD_S
) (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // host pins
  input wire config_select_n,
  output wire cts,
  output wire pullup_enable,
  output wire connect_led,
  output wire [7:0] alarm_gpio,
  // uart character ports
  input wire rx_valid,
  input wire [7:0] rx_data,
  output wire tx_valid,
  output reg [7:0] tx_data,
  input wire tx_ready,
  // radio core status and messages
  input wire mesh_joined,
  input wire link_up,
  input wire interference,
  output reg reset_msg_valid,
  output reg status_report_valid,
  output reg tamper_msg_valid,
  output reg [15:0] tamper_msg_data,
  input wire msg_ready,
  output reg core_reset,
  // interrupt
  output wire irq
);

  localparam ST_RUN = 3'h0;
  localparam ST_CONFIG = 3'h1;
  localparam ST_SLEEP = 3'h2;
  localparam ST_RESET = 3'h3;
  localparam ST_JOIN = 3'h4;

  reg [2:0] state;
  reg cfg_s1, cfg_s2;
  reg [31:0] ctrl;
  reg [`IRQ_W-1:0] irq_stat, irq_en;
  reg [15:0] rst_cnt;
  reg prompt_pend, xoff_pend, xon_pend;
  reg led;
  reg [7:0] tamper_min, since_hr, hr_min;
  reg [5:0] sec_cnt;
  reg alarm_on, was_alarm, msg_pend;
  reg [7:0] sec_in_min;
  wire sec_tick, xon_tick;
  reg [`IRQ_W-1:0] ev;
  wire wr_en = psel && penable && pwrite;
  wire cfg_low = !cfg_s2;

  // one-hot gpio decode, used for drive and readback
  function [7:0] one_hot;
    input [2:0] idx;
    begin
      one_hot = 8'h01 << idx;
    end
  endfunction

  // ==================================================
  // divider: one-second tick, also used as the xon tick
  tick_divider #(.PERIOD(XON_CYCLES)) u_sec (
    .pclk(pclk), .presetn(presetn), .clear(1'b0), .tick(sec_tick));
  assign xon_tick = sec_tick;

  // config pin synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_s1 <= 1'b1;
      cfg_s2 <= 1'b1;
    end else begin
      cfg_s1 <= config_select_n;
      cfg_s2 <= cfg_s1;
    end
  end

  // ==================================================
  // sleep / wake state machine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_RESET;
      rst_cnt <= 16'h0000;
      core_reset <= 1'b1;
    end else begin
      case (state)
        ST_RUN: if (cfg_low) state <= ST_CONFIG;
        ST_CONFIG: begin
          if (!cfg_low)
            state <= ST_RUN;
          else if (rx_valid && rx_data == `CHR_SLEEP)
            state <= ST_SLEEP; // [R2]
        end
        ST_SLEEP: begin
          if (!cfg_low) begin
            state <= ST_RESET; // [R3]
            rst_cnt <= 16'h0000;
            core_reset <= 1'b1;
          end
        end
        ST_RESET: begin
          if (rst_cnt == `RESET_CYC - 1) begin
            state <= ST_JOIN;
            core_reset <= 1'b0;
          end else
            rst_cnt <= rst_cnt + 16'h0001;
        end
        ST_JOIN: if (mesh_joined) state <= ST_RUN;
        default: state <= ST_RESET;
      endcase
    end
  end

  assign pullup_enable = (state != ST_SLEEP); // [R4]
  assign cts = (state == ST_RESET) || (state == ST_JOIN) || (state == ST_SLEEP); // [R6]
  assign connect_led = led;

  // ==================================================
  // serial characters: prompt, xoff, xon
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prompt_pend <= 1'b0;
      xoff_pend <= 1'b0;
      xon_pend <= 1'b0;
    end else begin
      if (state == ST_RUN && cfg_low)
        prompt_pend <= 1'b1;
      else if (tx_ready && !xoff_pend && prompt_pend)
        prompt_pend <= 1'b0;
      if (state == ST_RESET && rst_cnt == `RESET_CYC - 1 && ctrl[`CTRL_XONOFF])
        xoff_pend <= 1'b1; // [R7]
      else if (tx_ready)
        xoff_pend <= 1'b0;
      if (state == ST_RUN && ctrl[`CTRL_XONOFF] && xon_tick)
        xon_pend <= 1'b1; // [R8]
      else if (state == ST_JOIN && mesh_joined && ctrl[`CTRL_XONOFF])
        xon_pend <= 1'b1; // [R7]
      else if (tx_ready && !xoff_pend && !prompt_pend)
        xon_pend <= 1'b0;
    end
  end

  assign tx_valid = xoff_pend || prompt_pend || xon_pend;

  // tx data mux, xoff first
  always @* begin
    if (xoff_pend)
      tx_data = `CHR_XOFF; // [R8]
    else if (prompt_pend)
      tx_data = `CHR_PROMPT;
    else
      tx_data = `CHR_XON;
  end

  // ==================================================
  // led and wake messages
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led <= 1'b0;
      reset_msg_valid <= 1'b0;
      status_report_valid <= 1'b0;
    end else begin
      if (state == ST_SLEEP || state == ST_RESET)
        led <= 1'b0;
      else if (sec_tick)
        led <= !led; // [R9]
      if (state == ST_RESET && rst_cnt == `RESET_CYC - 1)
        reset_msg_valid <= 1'b1; // [R10]
      else if (msg_ready)
        reset_msg_valid <= 1'b0;
      if (state == ST_JOIN && mesh_joined && ctrl[`CTRL_REPORT])
        status_report_valid <= 1'b1; // [R11]
      else if (msg_ready && !reset_msg_valid)
        status_report_valid <= 1'b0;
    end
  end

  // ==================================================
  // tamper timing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_in_min <= 8'h00;
      tamper_min <= 8'h00;
      since_hr <= 8'h00;
      hr_min <= 8'h00;
      alarm_on <= 1'b0;
      was_alarm <= 1'b0;
      msg_pend <= 1'b0;
      tamper_msg_valid <= 1'b0;
      tamper_msg_data <= 16'h0000;
      sec_cnt <= 6'h00;
    end else begin
      if (!interference) begin
        sec_in_min <= 8'h00;
        tamper_min <= (alarm_on || msg_pend) ? tamper_min : 8'h00; // [R19] kept while message queued
        alarm_on <= 1'b0; // [R13]
        if (alarm_on) begin
          msg_pend <= 1'b1; // [R17]
          was_alarm <= 1'b1;
          since_hr <= 8'h00;
          hr_min <= 8'h00;
        end
      end else if (sec_tick) begin
        if (sec_in_min == MIN_TICKS - 1) begin
          sec_in_min <= 8'h00;
          if (tamper_min != 8'hFF)
            tamper_min <= tamper_min + 8'h01;
          if (tamper_min + 8'h01 >= ctrl[`CTRL_THR_HI:`CTRL_THR_LO] && ctrl[`CTRL_THR_HI:`CTRL_THR_LO] != 8'h00)
            alarm_on <= 1'b1; // [R16]
        end else
          sec_in_min <= sec_in_min + 8'h01;
      end
      if (interference && !alarm_on && tamper_min == 8'h00 && was_alarm && !msg_pend)
        was_alarm <= 1'b0;
      // hours since tamper ended
      if (!interference && was_alarm && sec_tick) begin
        if (sec_cnt == MIN_TICKS - 1) begin
          sec_cnt <= 6'h00;
          if (hr_min == `HOUR_MINUTES - 1) begin
            hr_min <= 8'h00;
            if (since_hr != 8'hFF)
              since_hr <= since_hr + 8'h01;
          end else
            hr_min <= hr_min + 8'h01;
        end else
          sec_cnt <= sec_cnt + 6'h01;
      end
      if (msg_pend && link_up && !tamper_msg_valid) begin
        tamper_msg_valid <= 1'b1; // [R17]
        tamper_msg_data <= {tamper_min, since_hr}; // [R18]
      end else if (tamper_msg_valid && msg_ready) begin
        tamper_msg_valid <= 1'b0;
        msg_pend <= 1'b0;
        was_alarm <= 1'b0;
      end
    end
  end

  // alarm gpio: selected pin low during alarm, others high
  assign alarm_gpio = alarm_on ? ~one_hot(ctrl[`CTRL_GPIO_HI:`CTRL_GPIO_LO]) : 8'hFF; // [R12] [R14]

  // ==================================================
  // interrupt events
  always @* begin
    ev = {`IRQ_W{1'b0}};
    ev[`IRQ_SLEEP] = (state == ST_CONFIG) && rx_valid && (rx_data == `CHR_SLEEP);
    ev[`IRQ_WAKE] = (state == ST_SLEEP) && !cfg_low;
    ev[`IRQ_JOIN] = (state == ST_JOIN) && mesh_joined;
    ev[`IRQ_ALARM] = interference && sec_tick && (sec_in_min == MIN_TICKS - 1) && !alarm_on &&
      (tamper_min + 8'h01 >= ctrl[`CTRL_THR_HI:`CTRL_THR_LO]) && (ctrl[`CTRL_THR_HI:`CTRL_THR_LO] != 8'h00);
    ev[`IRQ_MSG] = tamper_msg_valid && msg_ready;
  end

  // ==================================================
  // apb registers; set wins over clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET;
      irq_en <= {`IRQ_W{1'b0}};
      irq_stat <= {`IRQ_W{1'b0}};
    end else begin
      if (wr_en && paddr == `OFS_CTRL)
        ctrl <= {16'h0000, pwdata[15:0]};
      if (wr_en && paddr == `OFS_IRQ_EN)
        irq_en <= pwdata[`IRQ_W-1:0];
      if (wr_en && paddr == `OFS_IRQ_CLR)
        irq_stat <= (irq_stat & ~pwdata[`IRQ_W-1:0]) | ev;
      else
        irq_stat <= irq_stat | ev;
    end
  end

  // read mux
  always @* begin
    case (paddr)
      `OFS_CTRL: prdata = {16'h0000, ctrl[15:0]};
      `OFS_STATUS: prdata = {16'h0000, alarm_gpio, 2'b00, alarm_on, cts, pullup_enable, state};
      `OFS_IRQ_STAT: prdata = {27'h0000000, irq_stat};
      `OFS_IRQ_EN: prdata = {27'h0000000, irq_en};
      `OFS_TAMPER_MSG: prdata = {16'h0000, tamper_min, since_hr};
      default: prdata = 32'h0000_0000;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == `OFS_CTRL || paddr == `OFS_STATUS || paddr == `OFS_IRQ_STAT ||
    paddr == `OFS_IRQ_EN || paddr == `OFS_IRQ_CLR || paddr == `OFS_TAMPER_MSG);
  assign irq = |(irq_stat & irq_en);

endmodule

// File: sim/sleep_wake_chk.sv
/*
  port assertions for the sleep, wake and tamper alarm supervisor.
  assumes one pclk domain with presetn asynchronous and active low.
*/
`timescale 1ns/1ps
module sleep_wake_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  // pins and uart
  input wire logic cts,
  input wire logic pullup_enable,
  input wire logic [7:0] alarm_gpio,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  // radio core
  input wire logic mesh_joined,
  input wire logic link_up,
  input wire logic interference,
  input wire logic reset_msg_valid,
  input wire logic tamper_msg_valid,
  input wire logic core_reset
);
  logic [7:0] rst_len;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==================================================
  // length of the internal reset cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rst_len <= 8'h00;
    else
      rst_len <= core_reset ? rst_len + 8'h01 : 8'h00;
  end
  // ==================================================
  // assertions
  cts_reset_a: assert property (core_reset |-> cts)
    else $error("cts low during reset cycle");
  reset_len_a: assert property ($fell(core_reset) |-> $past(rst_len) >= 8'h17 && $past(rst_len) <= 8'h1A)
    else $error("reset cycle length wrong");
  reset_msg_a: assert property ($fell(core_reset) |-> ##[0:2] reset_msg_valid)
    else $error("no reset message after reset cycle");
  sleep_cmd_a: assert property ($fell(pullup_enable) |->
    $past(rx_valid && rx_data == 8'h5A) || $past(rx_valid && rx_data == 8'h5A, 2))
    else $error("pull-ups off without sleep character");
  wake_reset_a: assert property ($rose(pullup_enable) |-> ##[0:2] core_reset)
    else $error("wake without reset cycle");
  cts_join_a: assert property ($fell(cts) |-> mesh_joined || $past(mesh_joined))
    else $error("cts low without mesh join");
  xon_join_a: assert property (tx_valid && tx_data == 8'h11 |-> !cts)
    else $error("xon sent before join");
  alarm_on_a: assert property ($fell(&alarm_gpio) |-> interference && $countones(~alarm_gpio) == 1)
    else $error("alarm without interference or on several pins");
  alarm_off_a: assert property ($fell(interference) |-> ##[0:2] (alarm_gpio == 8'hFF))
    else $error("alarm pin stays low");
  msg_link_a: assert property ($rose(tamper_msg_valid) |-> link_up)
    else $error("tamper message without link");
  unmapped_a: assert property (psel && penable && paddr == 12'h018 |-> pslverr)
    else $error("unmapped access not refused");
endmodule
bind sleep_wake_tamper_alarm sleep_wake_chk u_sleep_wake_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pslverr(pslverr), .cts(cts), .pullup_enable(pullup_enable),
  .alarm_gpio(alarm_gpio), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
  .mesh_joined(mesh_joined), .link_up(link_up), .interference(interference), .reset_msg_valid(reset_msg_valid),
  .tamper_msg_valid(tamper_msg_valid), .core_reset(core_reset));

// File: sim/host_side_model.sv
/*
  host side of the uart: takes characters from the supervisor.
  assumes pclk and presetn of the supervisor.
*/
`timescale 1ns/1ps
module host_side_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // uart characters
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // last character taken
  output logic [7:0] last_char
);
  // ==================================================
  // slow uart: ready on alternate cycles only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      last_char <= 8'h00;
    end else begin
      tx_ready <= ~tx_ready;
      if (tx_valid && tx_ready)
        last_char <= tx_data;
    end
  end
endmodule

// File: sim/tb.sv
/*
  self-checking bench for the sleep, wake and tamper alarm supervisor.
  assumes the design, its checker and the host model are compiled first.
*/
`timescale 1ns/1ps
module tb;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, config_select_n, cts, pullup_enable, connect_led, e, led;
  logic rx_valid, tx_valid, tx_ready, mesh_joined, link_up, interference, msg_ready, core_reset, irq;
  logic reset_msg_valid, status_report_valid, tamper_msg_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] rx_data, tx_data, alarm_gpio, last_char;
  logic [15:0] tamper_msg_data;
  int miscompares = 0;
  int n_tests = 0;
  int i;
  // ==================================================
  // clock, design and host
  always #20 pclk = ~pclk;
  sleep_wake_tamper_alarm #(.XON_CYCLES(20), .MIN_TICKS(2)) u_sleep_wake_tamper_alarm (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .config_select_n(config_select_n), .cts(cts),
    .pullup_enable(pullup_enable), .connect_led(connect_led), .alarm_gpio(alarm_gpio), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .mesh_joined(mesh_joined),
    .link_up(link_up), .interference(interference), .reset_msg_valid(reset_msg_valid),
    .status_report_valid(status_report_valid), .tamper_msg_valid(tamper_msg_valid),
    .tamper_msg_data(tamper_msg_data), .msg_ready(msg_ready), .core_reset(core_reset), .irq(irq));
  host_side_model u_host_side_model (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .last_char(last_char));
  // ==================================================
  // compare, verdict and apb transfer
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 16) begin
      miscompares++;
      final_report();
    end
    @(posedge pclk);
  endtask
  // ==================================================
  // scenarios
  task reset_walk;
    chk(core_reset, 1'b1);
    chk(cts, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h0000_0100);
    for (i = 0; i < 60 && reset_msg_valid !== 1'b1; i++) @(posedge pclk);
    chk(reset_msg_valid, 1'b1);
    chk(cts, 1'b1);
    msg_ready <= 1'b1;
    mesh_joined <= 1'b1;
    for (i = 0; i < 20 && cts !== 1'b0; i++) @(posedge pclk);
    chk(cts, 1'b0);
    chk(status_report_valid, 1'b0);
    apb(1'b1, 12'h000, 32'h0000_0217);
  endtask
  task sleep_wake;
    config_select_n <= 1'b0;
    for (i = 0; i < 60 && last_char !== 8'h3E; i++) @(posedge pclk);
    chk(last_char, 8'h3E);
    rx_data <= 8'h5A;
    rx_valid <= 1'b1;
    @(posedge pclk);
    rx_valid <= 1'b0;
    for (i = 0; i < 10 && pullup_enable !== 1'b0; i++) @(posedge pclk);
    chk(pullup_enable, 1'b0);
    mesh_joined <= 1'b0;
    msg_ready <= 1'b0;
    config_select_n <= 1'b1;
    for (i = 0; i < 10 && core_reset !== 1'b1; i++) @(posedge pclk);
    chk(core_reset, 1'b1);
    for (i = 0; i < 60 && reset_msg_valid !== 1'b1; i++) @(posedge pclk);
    chk(reset_msg_valid, 1'b1);
    for (i = 0; i < 20 && last_char !== 8'h13; i++) @(posedge pclk);
    chk(last_char, 8'h13);
    chk(cts, 1'b1);
    mesh_joined <= 1'b1;
    for (i = 0; i < 20 && status_report_valid !== 1'b1; i++) @(posedge pclk);
    chk(status_report_valid, 1'b1);
    chk(cts, 1'b0);
    for (i = 0; i < 20 && last_char !== 8'h11; i++) @(posedge pclk);
    chk(last_char, 8'h11);
    msg_ready <= 1'b1;
    led = connect_led;
    repeat (20) @(posedge pclk);
    chk(connect_led, !led);
  endtask
  task tamper_flow;
    interference <= 1'b1;
    repeat (50) @(posedge pclk);
    interference <= 1'b0;
    @(posedge pclk);
    interference <= 1'b1;
    repeat (60) @(posedge pclk);
    chk(alarm_gpio, 8'hFF);
    for (i = 0; i < 200 && alarm_gpio !== 8'hDF; i++) @(posedge pclk);
    chk(alarm_gpio, 8'hDF);
    interference <= 1'b0;
    for (i = 0; i < 5 && alarm_gpio !== 8'hFF; i++) @(posedge pclk);
    chk(alarm_gpio, 8'hFF);
    chk(tamper_msg_valid, 1'b0);
    link_up <= 1'b1;
    for (i = 0; i < 20 && tamper_msg_valid !== 1'b1; i++) @(posedge pclk);
    chk(tamper_msg_valid, 1'b1);
    chk(tamper_msg_data, 16'h0200);
  endtask
  task irq_map;
    apb(1'b0, 12'h008, 32'h0);
    chk(q, 32'h0000_001F);
    chk(irq, 1'b0);
    apb(1'b1, 12'h00C, 32'h0000_0008);
    chk(irq, 1'b1);
    apb(1'b1, 12'h010, 32'h0000_0008);
    chk(irq, 1'b0);
    apb(1'b0, 12'h008, 32'h0);
    chk(q, 32'h0000_0017);
    apb(1'b0, 12'h018, 32'h0);
    chk(e, 1'b1);
    chk(q, 32'h0);
  endtask
  // ==================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, rx_valid, mesh_joined, link_up, interference, msg_ready} = 9'h000;
    config_select_n = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    rx_data = 8'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reset_walk();
    sleep_wake();
    tamper_flow();
    irq_map();
    final_report();
  end
endmodule
